/* bench/ibpe_bus_slave.sv */
// behavioural slave device on the far side of the two-wire bus
// assumes pulled-up wires built by the bench from every party's pull-low
`timescale 1ns/100ps
module ibpe_bus_slave #(
	parameter logic [6:0] ADDR = 7'h2c
) (
	input wire logic scl,
	input wire logic sda,
	input wire logic clash,
	input wire logic [7:0] tx_byte,
	input wire logic [15:0] stretch_ns,
	output logic scl_low,
	output logic sda_low,
	output logic [7:0] rx_byte
);
	logic restart;

	// sample on each scl rise, msb first
	task automatic get_byte(output logic [7:0] v);
		for (int i = 0; i < 8; i++) begin
			@(posedge scl);
			v = {v[6:0], sda};
		end
	endtask

	// ack after 8th fall, release after 9th, then hold scl
	task automatic give_ack();
		@(negedge scl);
		#100 sda_low = 1'b1;
		@(negedge scl);
		#100 sda_low = 1'b0;
		scl_low = 1'b1;
		#(stretch_ns) scl_low = 1'b0;
	endtask

	// send a byte, release for the master's ack slot
	task automatic send_byte(input logic [7:0] v, output logic acked);
		for (int i = 7; i >= 0; i--) begin
			sda_low = !v[i];
			@(negedge scl);
			#100;
		end
		sda_low = 1'b0;
		@(posedge scl);
		acked = !sda;
		@(negedge scl);
		#100;
	endtask

	task automatic serve();
		logic [7:0] v;
		logic acked;
		get_byte(v);
		if (v[7:1] == ADDR) begin
			give_ack();
			if (v[0]) begin
				acked = 1'b1;
				while (acked) send_byte(tx_byte, acked);
			end else begin
				while (!clash) begin
					get_byte(v);
					rx_byte = v;
					give_ack();
				end
				// a second talker pulls sda low, then frees it with a stop
				#100 sda_low = 1'b1;
				@(posedge scl);
				#4000 sda_low = 1'b0;
			end
		end
		wait (1'b0);
	endtask

	// ****************************************
	// framing
	// ****************************************
	// any start restarts address phase, stop idles
	initial begin
		scl_low = 1'b0;
		sda_low = 1'b0;
		rx_byte = 8'h00;
		restart = 1'b0;
		forever begin
			if (!restart) @(negedge sda iff scl === 1'b1);
			restart = 1'b0;
			fork
				serve();
				begin
					@(negedge sda iff scl === 1'b1);
					restart = 1'b1;
				end
				@(posedge sda iff scl === 1'b1);
			join_any
			disable fork;
			scl_low = 1'b0;
			sda_low = 1'b0;
		end
	end
endmodule // ibpe_bus_slave

/* bench/ibpe_engine_tb.sv */
// self-checking bench: engine master talks to a far slave model and to its own slave
// assumes pull-ups on both wires, modelled by the wired-and below
`timescale 1ns/100ps
module ibpe_engine_tb;
	typedef struct packed {
		logic [9:0] val;
		logic [9:0] mask;
	} ibpe_note_t;
	localparam logic [6:0] PEER = 7'h2c;
	localparam logic [6:0] SELF = 7'h51;
	logic ref_clk, reset_n, scl, sda, scl_o, scl_oe, sda_o, sda_oe, cmd_valid, cmd_ready;
	logic rsp_valid, rx_valid, tx_valid, tx_ready, bus_busy, collision, p_scl, p_sda, clash;
	logic [7:0] rx_data, tx_data, tx_byte, rx_byte, d;
	logic [15:0] stretch_ns;
	ibpe_pkg::ibpe_req_t cmd;
	ibpe_pkg::ibpe_rsp_t rsp;
	ibpe_note_t rsp_q[$];
	ibpe_note_t e;
	logic [7:0] rx_q[$];
	int fails, compares;

	// open drain: any party pulling low wins
	assign scl = !(scl_oe || p_scl);
	assign sda = !(sda_oe || p_sda);

	ibpe_engine dut (.ref_clk(ref_clk), .reset_n(reset_n), .scl_i(scl), .scl_o(scl_o),
		.scl_oe(scl_oe), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .cmd_valid(cmd_valid),
		.cmd_ready(cmd_ready), .cmd(cmd), .rsp_valid(rsp_valid), .rsp(rsp), .slave_en(1'b1),
		.own_addr(SELF), .rx_valid(rx_valid), .rx_data(rx_data), .tx_valid(tx_valid),
		.tx_data(tx_data), .tx_ready(tx_ready), .bus_busy(bus_busy), .collision(collision));
	ibpe_bus_slave #(.ADDR(PEER)) peer (.scl(scl), .sda(sda), .clash(clash),
		.tx_byte(tx_byte), .stretch_ns(stretch_ns), .scl_low(p_scl), .sda_low(p_sda),
		.rx_byte(rx_byte));

	// ****************************************
	// checking
	// ****************************************
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic finish_test();
		if (fails == 0 && compares > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	always @(posedge ref_clk) begin
		if (rsp_valid === 1'b1) begin
			e = '{val: 10'h3ff, mask: 10'h3ff};
			if (rsp_q.size() > 0) begin
				e = rsp_q.pop_front();
			end
			check(16'(rsp & e.mask), 16'(e.val & e.mask));
			check(16'(collision), 16'(e.val[0] & e.mask[0]));
		end
		if (rx_valid === 1'b1) begin
			check(16'(rx_data), (rx_q.size() > 0) ? 16'(rx_q.pop_front()) : 16'hffff);
		end
	end

	// ****************************************
	// command drivers
	// ****************************************
	// a command is held until taken, then the answer is awaited under a bound
	task automatic issue(input ibpe_pkg::ibpe_cmd_t c, input logic [7:0] dt, input logic nk,
			input logic [9:0] val, input logic [9:0] mask);
		int n;
		n = 0;
		cmd_valid <= 1'b1;
		cmd <= '{cmd: c, data: dt, nack: nk};
		@(posedge ref_clk);
		while (cmd_ready !== 1'b1 && n < 30000) begin
			@(posedge ref_clk);
			n++;
		end
		cmd_valid <= 1'b0;
		rsp_q.push_back('{val: val, mask: mask});
		while (rsp_valid !== 1'b1 && n < 30000) begin
			@(posedge ref_clk);
			n++;
		end
		check(16'(n < 30000), 16'h0001);
	endtask

	task automatic st(input ibpe_pkg::ibpe_cmd_t c);
		issue(c, 8'h00, 1'b0, 10'h000, 10'h001);
	endtask

	task automatic wr(input logic [7:0] dt, input logic no_ack);
		issue(ibpe_pkg::IBPE_CMD_WRITE, dt, 1'b0, {dt, no_ack, 1'b0}, 10'h3ff);
	endtask

	task automatic rd(input logic [7:0] exp, input logic nk);
		issue(ibpe_pkg::IBPE_CMD_READ, 8'hff, nk, {exp, 2'b00}, 10'h3fd);
	endtask

	task automatic settle_busy(input logic exp);
		repeat (400) @(posedge ref_clk);
		check(16'(bus_busy), 16'(exp));
	endtask

	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end

	initial begin
		#2000000;
		fails++;
		finish_test();
	end

	// ****************************************
	// scenarios
	// ****************************************
	initial begin
		reset_n = 1'b0;
		cmd_valid = 1'b0;
		cmd = '{cmd: ibpe_pkg::IBPE_CMD_WRITE, data: 8'h00, nack: 1'b0};
		tx_valid = 1'b0;
		tx_data = 8'h00;
		tx_byte = 8'h00;
		clash = 1'b0;
		stretch_ns = 16'h0000;
		void'($urandom(32'h0000_119f));
		repeat (6) @(posedge ref_clk);
		check(16'(cmd_ready), 16'h0000);
		reset_n <= 1'b1;
		@(posedge ref_clk);
		// stretched write, combined read after restart
		d = 8'($urandom());
		tx_byte <= 8'($urandom());
		stretch_ns <= 16'($urandom_range(8000, 3000));
		st(ibpe_pkg::IBPE_CMD_START);
		settle_busy(1'b1);
		wr({PEER, 1'b0}, 1'b0);
		wr(d, 1'b0);
		check(16'(rx_byte), 16'(d));
		st(ibpe_pkg::IBPE_CMD_START);
		wr({PEER, 1'b1}, 1'b0);
		rd(tx_byte, 1'b0);
		rd(tx_byte, 1'b1);
		st(ibpe_pkg::IBPE_CMD_STOP);
		settle_busy(1'b0);
		st(ibpe_pkg::IBPE_CMD_START);
		wr({7'h33, 1'b0}, 1'b1);
		st(ibpe_pkg::IBPE_CMD_STOP);
		// own slave: write a byte, then read one after a repeated start
		stretch_ns <= 16'h0000;
		d = 8'($urandom());
		tx_data <= 8'($urandom());
		tx_valid <= 1'b1;
		st(ibpe_pkg::IBPE_CMD_START);
		wr({SELF, 1'b0}, 1'b0);
		rx_q.push_back(d);
		wr(d, 1'b0);
		st(ibpe_pkg::IBPE_CMD_START);
		wr({SELF, 1'b1}, 1'b0);
		rd(tx_data, 1'b1);
		tx_valid <= 1'b0;
		st(ibpe_pkg::IBPE_CMD_STOP);
		// loss in the data phase, wait for stop, then retry
		clash <= 1'b1;
		st(ibpe_pkg::IBPE_CMD_START);
		wr({PEER, 1'b0}, 1'b0);
		issue(ibpe_pkg::IBPE_CMD_WRITE, 8'hff, 1'b0, 10'h001, 10'h001);
		clash <= 1'b0;
		settle_busy(1'b0);
		st(ibpe_pkg::IBPE_CMD_START);
		wr({PEER, 1'b0}, 1'b0);
		st(ibpe_pkg::IBPE_CMD_STOP);
		// let the monitor take the last answer before the queue is judged
		@(posedge ref_clk);
		check(16'({scl_o, sda_o}), 16'h0000);
		check(16'({tx_ready, scl_oe, sda_oe}), 16'h0000);
		check(16'(rsp_q.size()), 16'h0000);
		finish_test();
	end
endmodule // ibpe_engine_tb

/* verilog/ibpe_cond_detect.sv */
// start, stop, clock edge and busy detection from filtered lines
// assumes both inputs are already synchronous to ref_clk
`timescale 1ns/100ps
module ibpe_cond_detect (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire ibpe_pkg::ibpe_line_t line_filt,
	output ibpe_pkg::ibpe_cond_t cond
);
	typedef struct packed {
		ibpe_pkg::ibpe_line_t prev;
		logic seen_low;
		ibpe_pkg::ibpe_cond_t cond;
	} ibpe_cond_state_t;

	ibpe_cond_state_t st;
	ibpe_cond_state_t next_st;

	// ****************************************
	// detection
	// ****************************************
	always_comb begin
		next_st = st;
		next_st.prev = line_filt;
		next_st.cond.start = st.prev.scl && line_filt.scl && st.prev.sda && !line_filt.sda;
		next_st.cond.stop = st.prev.scl && line_filt.scl && !st.prev.sda && line_filt.sda
			&& st.seen_low;
		next_st.cond.scl_rise = !st.prev.scl && line_filt.scl;
		next_st.cond.scl_fall = st.prev.scl && !line_filt.scl;
		if (next_st.cond.start) begin
			next_st.seen_low = 1'b0;
		end else if (!line_filt.scl) begin
			next_st.seen_low = 1'b1;
		end
		if (next_st.cond.start) begin
			next_st.cond.busy = 1'b1;
		end else if (next_st.cond.stop) begin
			next_st.cond.busy = 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			st <= '{prev: ibpe_pkg::LINE_IDLE, seen_low: 1'b0, cond: '0};
		end else begin
			st <= next_st;
		end
	end

	assign cond = st.cond;

	default clocking @(posedge ref_clk); endclocking
	default disable iff (!reset_n);

	chk_stop_after_low: assert property (
		cond.stop |-> $past(st.seen_low) && !cond.start)
		else $error("stop seen without scl low since start");

	chk_busy_follows: assert property (
		cond.start |-> cond.busy)
		else $error("busy not raised on start");

endmodule // ibpe_cond_detect

/* verilog/ibpe_engine.sv */
// two-wire bus protocol engine: master and slave byte engines
// assumes an open-drain pad: oe high pulls the line low, o is always zero
`timescale 1ns/100ps
module ibpe_engine (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic scl_i,
	output logic scl_o,
	output logic scl_oe,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe,
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire ibpe_pkg::ibpe_req_t cmd,
	output logic rsp_valid,
	output ibpe_pkg::ibpe_rsp_t rsp,
	input wire logic slave_en,
	input wire logic [6:0] own_addr,
	output logic rx_valid,
	output logic [7:0] rx_data,
	input wire logic tx_valid,
	input wire logic [7:0] tx_data,
	output logic tx_ready,
	output logic bus_busy,
	output logic collision
);
	typedef struct packed {
		ibpe_pkg::ibpe_mst_t ms;
		logic [1:0] ph;
		logic [7:0] div;
		logic [3:0] mbit;
		logic [7:0] msh;
		logic m_rd;
		logic m_nack_tx;
		logic m_scl_low;
		logic m_sda_low;
		logic rsp_valid;
		ibpe_pkg::ibpe_rsp_t rsp;
		logic collide;
		ibpe_pkg::ibpe_slv_t ss;
		logic [3:0] scnt;
		logic [7:0] ssh;
		logic s_sda_low;
		logic s_hold;
		logic s_ack_ok;
		logic rx_valid;
		logic [7:0] rx_data;
	} ibpe_eng_state_t;

	ibpe_eng_state_t st;
	ibpe_eng_state_t next_st;
	ibpe_pkg::ibpe_line_t lf;
	ibpe_pkg::ibpe_cond_t cond;
	logic tick;
	logic m_act;

	// ****************************************
	// line conditioning
	// ****************************************
	ibpe_line_filter u_filter (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.line_raw('{scl: scl_i, sda: sda_i}),
		.line_filt(lf)
	);

	ibpe_cond_detect u_cond (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.line_filt(lf),
		.cond(cond)
	);

	// ****************************************
	// helpers
	// ****************************************
	// lost arbitration: release both lines and report at once
	function automatic ibpe_eng_state_t ibpe_lose(input ibpe_eng_state_t s);
		ibpe_eng_state_t r;
		r = s;
		r.ms = ibpe_pkg::IBPE_M_LOST;
		r.m_sda_low = 1'b0;
		r.m_scl_low = 1'b0;
		r.collide = 1'b1;
		r.rsp_valid = 1'b1;
		r.rsp.lost = 1'b1;
		return r;
	endfunction

	assign m_act = st.ms != ibpe_pkg::IBPE_M_IDLE && st.ms != ibpe_pkg::IBPE_M_LOST;
	assign cmd_ready = (st.ms == ibpe_pkg::IBPE_M_IDLE && cmd.cmd == ibpe_pkg::IBPE_CMD_START
		&& !cond.busy) || st.ms == ibpe_pkg::IBPE_M_HOLD;

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		next_st = st;
		tick = 1'b0;
		next_st.rsp_valid = 1'b0;
		next_st.collide = 1'b0;
		next_st.rx_valid = 1'b0;
		// divider reloaded while scl held low in phase 1
		if (m_act) begin
			if (st.ph == 2'h1 && !lf.scl) begin
				next_st.div = ibpe_pkg::QTR_LOAD;
			end else if (st.div == 8'h00) begin
				tick = 1'b1;
				next_st.div = ibpe_pkg::QTR_LOAD;
			end else begin
				next_st.div = st.div - 8'h01;
			end
		end
		case (st.ms)
			ibpe_pkg::IBPE_M_IDLE: begin
				next_st.m_scl_low = 1'b0;
				next_st.m_sda_low = 1'b0;
				if (cmd_valid && cmd_ready) begin
					next_st.ms = ibpe_pkg::IBPE_M_START;
					next_st.ph = 2'h0;
					next_st.div = ibpe_pkg::QTR_LOAD;
				end
			end
			ibpe_pkg::IBPE_M_HOLD: begin
				if (cmd_valid) begin
					next_st.ph = 2'h0;
					next_st.div = ibpe_pkg::QTR_LOAD;
					next_st.mbit = 4'h0;
					case (cmd.cmd)
						ibpe_pkg::IBPE_CMD_START: begin
							next_st.ms = ibpe_pkg::IBPE_M_START;
							next_st.m_sda_low = 1'b0;
						end
						ibpe_pkg::IBPE_CMD_WRITE: begin
							next_st.ms = ibpe_pkg::IBPE_M_BIT;
							next_st.m_rd = 1'b0;
							next_st.msh = cmd.data;
							next_st.m_sda_low = !cmd.data[7];
						end
						ibpe_pkg::IBPE_CMD_READ: begin
							next_st.ms = ibpe_pkg::IBPE_M_BIT;
							next_st.m_rd = 1'b1;
							next_st.m_nack_tx = cmd.nack;
							next_st.m_sda_low = 1'b0;
						end
						ibpe_pkg::IBPE_CMD_STOP: begin
							next_st.ms = ibpe_pkg::IBPE_M_STOP;
							next_st.m_sda_low = 1'b1;
						end
						default: next_st.ms = ibpe_pkg::IBPE_M_HOLD;
					endcase
				end
			end
			ibpe_pkg::IBPE_M_START: begin
				if (tick) begin
					next_st.ph = st.ph + 2'h1;
					case (st.ph)
						2'h0: next_st.m_scl_low = 1'b0;
						2'h1: begin
							if (!lf.sda) begin
								next_st = ibpe_lose(next_st);
							end else begin
								next_st.m_sda_low = 1'b1;
							end
						end
						2'h2: next_st.m_scl_low = 1'b1;
						default: begin
							next_st.ms = ibpe_pkg::IBPE_M_HOLD;
							next_st.rsp_valid = 1'b1;
							next_st.rsp = '0;
						end
					endcase
				end
			end
			ibpe_pkg::IBPE_M_BIT: begin
				if (tick) begin
					next_st.ph = st.ph + 2'h1;
					case (st.ph)
						2'h0: next_st.m_scl_low = 1'b0;
						2'h1: begin
							if (!st.m_rd && st.mbit < ibpe_pkg::BIT_ACK && !st.m_sda_low
								&& !lf.sda) begin
								next_st = ibpe_lose(next_st);
							end else if (st.mbit < ibpe_pkg::BIT_ACK) begin
								next_st.msh = {st.msh[6:0], lf.sda};
							end else if (!st.m_rd) begin
								next_st.rsp.nack = lf.sda;
							end
						end
						2'h2: next_st.m_scl_low = 1'b1;
						default: begin
							if (st.mbit == ibpe_pkg::BIT_ACK) begin
								next_st.ms = ibpe_pkg::IBPE_M_HOLD;
								next_st.rsp_valid = 1'b1;
								next_st.rsp.data = st.msh;
								next_st.rsp.lost = 1'b0;
								if (st.m_rd) begin
									next_st.rsp.nack = st.m_nack_tx;
								end
							end else begin
								next_st.mbit = st.mbit + 4'h1;
								// master ack or nack on read
								if (st.mbit + 4'h1 < ibpe_pkg::BIT_ACK) begin
									next_st.m_sda_low = !st.m_rd && !st.msh[7];
								end else begin
									next_st.m_sda_low = st.m_rd && !st.m_nack_tx;
								end
							end
						end
					endcase
				end
			end
			ibpe_pkg::IBPE_M_STOP: begin
				if (tick) begin
					next_st.ph = st.ph + 2'h1;
					case (st.ph)
						2'h0: next_st.m_scl_low = 1'b0;
						2'h1: next_st.m_sda_low = 1'b0;
						2'h2: next_st.m_sda_low = 1'b0;
						default: begin
							if (!lf.sda) begin
								next_st = ibpe_lose(next_st);
							end else begin
								next_st.ms = ibpe_pkg::IBPE_M_IDLE;
								next_st.rsp_valid = 1'b1;
								next_st.rsp.lost = 1'b0;
							end
						end
					endcase
				end
			end
			ibpe_pkg::IBPE_M_LOST: begin
				next_st.m_sda_low = 1'b0;
				next_st.m_scl_low = 1'b0;
				if (cond.stop || !cond.busy) begin
					next_st.ms = ibpe_pkg::IBPE_M_IDLE;
				end
			end
			default: next_st.ms = ibpe_pkg::IBPE_M_IDLE;
		endcase

		// ****************************************
		// slave
		// ****************************************
		if (!slave_en || cond.stop) begin
			next_st.ss = ibpe_pkg::IBPE_S_IDLE;
			next_st.s_sda_low = 1'b0;
			next_st.s_hold = 1'b0;
		end else if (cond.start) begin
			next_st.ss = ibpe_pkg::IBPE_S_ADDR;
			next_st.scnt = 4'h0;
			next_st.s_sda_low = 1'b0;
			next_st.s_hold = 1'b0;
		end else if (st.ss != ibpe_pkg::IBPE_S_IDLE) begin
			if (st.s_hold) begin
				if (tx_valid) begin
					next_st.ssh = tx_data;
					next_st.s_sda_low = !tx_data[7];
					next_st.s_hold = 1'b0;
				end
			end else if (cond.scl_rise) begin
				next_st.scnt = st.scnt + 4'h1;
				if (st.scnt < ibpe_pkg::BIT_ACK) begin
					next_st.ssh = {st.ssh[6:0], lf.sda};
					if (st.ss == ibpe_pkg::IBPE_S_TX && !st.s_sda_low && !lf.sda) begin
						next_st.collide = 1'b1;
						next_st.ss = ibpe_pkg::IBPE_S_IDLE;
					end
					if (st.ss == ibpe_pkg::IBPE_S_RX && st.scnt == 4'h7) begin
						next_st.rx_valid = 1'b1;
						next_st.rx_data = {st.ssh[6:0], lf.sda};
					end
				end else begin
					next_st.s_ack_ok = !lf.sda;
				end
			end else if (cond.scl_fall) begin
				if (st.scnt == ibpe_pkg::BIT_ACK) begin
					case (st.ss)
						ibpe_pkg::IBPE_S_ADDR: begin
							if (st.ssh[7:1] == own_addr) begin
								next_st.s_sda_low = 1'b1;
								next_st.ss = st.ssh[0] ? ibpe_pkg::IBPE_S_TX : ibpe_pkg::IBPE_S_RX;
							end else begin
								next_st.ss = ibpe_pkg::IBPE_S_IDLE;
							end
						end
						ibpe_pkg::IBPE_S_RX: next_st.s_sda_low = 1'b1;
						default: next_st.s_sda_low = 1'b0;
					endcase
				end else if (st.scnt == ibpe_pkg::BIT_END) begin
					next_st.scnt = 4'h0;
					next_st.s_sda_low = 1'b0;
					if (st.ss == ibpe_pkg::IBPE_S_TX) begin
						if (st.s_ack_ok) begin
							next_st.s_hold = 1'b1;
						end else begin
							next_st.ss = ibpe_pkg::IBPE_S_IDLE;
						end
					end
				end else if (st.ss == ibpe_pkg::IBPE_S_TX && st.scnt != 4'h0) begin
					// slave data moves on falling scl
					next_st.s_sda_low = !st.ssh[7];
				end
			end
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	// open-drain: only ever pull low
	assign scl_o = 1'b0;
	assign sda_o = 1'b0;
	assign scl_oe = st.m_scl_low || st.s_hold;
	assign sda_oe = st.m_sda_low || st.s_sda_low;
	assign rsp_valid = st.rsp_valid;
	assign rsp = st.rsp;
	assign rx_valid = st.rx_valid;
	assign rx_data = st.rx_data;
	assign tx_ready = st.s_hold;
	assign bus_busy = cond.busy;
	assign collision = st.collide;

	// ****************************************
	// checks
	// ****************************************
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!reset_n);

	chk_start_scl_high: assert property (
		st.ms == ibpe_pkg::IBPE_M_START && $rose(st.m_sda_low) |-> !st.m_scl_low && $past(lf.scl))
		else $error("start pulled sda with scl not high");

	chk_data_scl_low: assert property (
		st.ms == ibpe_pkg::IBPE_M_BIT && $changed(st.m_sda_low) && $past(st.ms) == st.ms
		|-> st.m_scl_low && $past(st.m_scl_low))
		else $error("master data moved while scl released");

	chk_msb_first: assert property (
		st.ms == ibpe_pkg::IBPE_M_BIT && st.ph == 2'h0 && !st.m_rd && st.mbit < 4'h8
		|-> st.m_sda_low == !st.msh[7])
		else $error("write bit is not the shift msb");

	chk_stop_scl_high: assert property (
		st.ms == ibpe_pkg::IBPE_M_STOP && $fell(st.m_sda_low) |-> !st.m_scl_low && $past(lf.scl))
		else $error("stop released sda with scl not high");

	chk_stretch_wait: assert property (
		st.ms == ibpe_pkg::IBPE_M_BIT && st.ph == 2'h1 && !lf.scl |=> st.ph == 2'h1)
		else $error("master moved on while scl held low");

	chk_lost_release: assert property (
		$rose(st.ms == ibpe_pkg::IBPE_M_LOST) |-> collision && rsp_valid && rsp.lost
		##1 (!st.m_scl_low && !st.m_sda_low)[*2])
		else $error("lost master kept driving");

	chk_busy_refuse: assert property (
		st.ms == ibpe_pkg::IBPE_M_IDLE && cond.busy |-> !cmd_ready)
		else $error("start taken while bus busy");

	chk_slave_ack: assert property (
		cond.scl_fall && st.ss == ibpe_pkg::IBPE_S_RX && st.scnt == 4'h8 && slave_en
		&& !cond.stop && !cond.start |=> sda_oe)
		else $error("slave did not ack a written byte");

	chk_restart_rearm: assert property (
		cond.start && slave_en && !cond.stop |=> st.ss == ibpe_pkg::IBPE_S_ADDR
		&& st.scnt == 4'h0 && !st.s_sda_low)
		else $error("start did not rearm slave");

	chk_collision_cause: assert property (
		collision |-> !$past(lf.sda))
		else $error("collision flagged with sda high");

	chk_ack_release: assert property (
		st.ms == ibpe_pkg::IBPE_M_BIT && !st.m_rd && st.mbit == 4'h8 |-> !st.m_sda_low)
		else $error("master drove sda in write ack slot");

endmodule // ibpe_engine

/* verilog/ibpe_line_filter.sv */
// two-flop synchroniser and glitch filter for both bus lines
// assumes raw pad levels arrive asynchronously to ref_clk
`timescale 1ns/100ps
module ibpe_line_filter (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire ibpe_pkg::ibpe_line_t line_raw,
	output ibpe_pkg::ibpe_line_t line_filt
);
	typedef struct packed {
		logic [1:0] s1;
		logic [1:0] s2;
		logic [1:0][1:0] cnt;
		logic [1:0] filt;
	} ibpe_filt_state_t;

	ibpe_filt_state_t st;
	ibpe_filt_state_t next_st;

	// ****************************************
	// filter
	// ****************************************
	// sync then filter
	always_comb begin
		next_st = st;
		next_st.s1 = line_raw;
		next_st.s2 = st.s1;
		for (int i = 0; i < 2; i++) begin
			if (st.s2[i] == st.filt[i]) begin
				next_st.cnt[i] = 2'h0;
			end else if (st.cnt[i] == ibpe_pkg::FILT_LAST) begin
				next_st.cnt[i] = 2'h0;
				next_st.filt[i] = st.s2[i];
			end else begin
				next_st.cnt[i] = st.cnt[i] + 2'h1;
			end
		end
	end

	// lines idle high, so reset to released levels
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			st <= '{s1: ibpe_pkg::LINE_IDLE, s2: ibpe_pkg::LINE_IDLE, cnt: '0,
				filt: ibpe_pkg::LINE_IDLE};
		end else begin
			st <= next_st;
		end
	end

	assign line_filt = st.filt;

	default clocking @(posedge ref_clk); endclocking
	default disable iff (!reset_n);

	chk_filter_settled: assert property (
		$changed(st.filt[0]) |-> $past(st.s2[0], 1) == st.filt[0] && $past(st.s2[0], 2) == st.filt[0])
		else $error("sda filter moved on a short pulse");

endmodule // ibpe_line_filter

/* verilog/ibpe_pkg.sv */
// constants and carrier types for the two-wire bus protocol engine
// assumes a single 50 MHz clock and an open-drain pad outside the design
package ibpe_pkg;

	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_PERIOD_NS = 20;
	localparam int SCL_PERIOD_NS = 10000;
	localparam int FILT_NS = 60;
	// quarter of a bus clock period, longest time so rounded down
	localparam int QTR_CYC = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
	localparam logic [7:0] QTR_LOAD = 8'(QTR_CYC - 1);
	// a level must stand this many cycles before the filter accepts it
	localparam int FILT_CYC = (FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [1:0] FILT_LAST = 2'(FILT_CYC - 1);
	localparam logic [3:0] BIT_ACK = 4'h8;
	localparam logic [3:0] BIT_END = 4'h9;
	localparam logic [1:0] LINE_IDLE = 2'h3;

	// ****************************************
	// carriers
	// ****************************************
	typedef enum logic [1:0] {
		IBPE_CMD_START = 2'b00,
		IBPE_CMD_WRITE = 2'b01,
		IBPE_CMD_READ = 2'b10,
		IBPE_CMD_STOP = 2'b11
	} ibpe_cmd_t;

	typedef struct packed {
		ibpe_cmd_t cmd;
		logic [7:0] data;
		logic nack;
	} ibpe_req_t;

	typedef struct packed {
		logic [7:0] data;
		logic nack;
		logic lost;
	} ibpe_rsp_t;

	typedef struct packed {
		logic scl;
		logic sda;
	} ibpe_line_t;

	typedef struct packed {
		logic start;
		logic stop;
		logic scl_rise;
		logic scl_fall;
		logic busy;
	} ibpe_cond_t;

	typedef enum logic [2:0] {
		IBPE_M_IDLE = 3'b000,
		IBPE_M_START = 3'b001,
		IBPE_M_HOLD = 3'b010,
		IBPE_M_BIT = 3'b011,
		IBPE_M_STOP = 3'b100,
		IBPE_M_LOST = 3'b101
	} ibpe_mst_t;

	typedef enum logic [1:0] {
		IBPE_S_IDLE = 2'b00,
		IBPE_S_ADDR = 2'b01,
		IBPE_S_RX = 2'b10,
		IBPE_S_TX = 2'b11
	} ibpe_slv_t;

endpackage
